// ===== inc/stdc_pkg.sv
`default_nettype none
package stdc_pkg;
   // Register port geometry
   localparam int STDC_ADDR_W = 4;
   localparam int STDC_DATA_W = 32;
   localparam int STDC_CNT_W = 24;

   // Byte offsets of the four word registers
   localparam logic [STDC_ADDR_W-1:0] STDC_OFS_CTRL = 4'h0;
   localparam logic [STDC_ADDR_W-1:0] STDC_OFS_RESTART = 4'h4;
   localparam logic [STDC_ADDR_W-1:0] STDC_OFS_COUNT = 4'h8;
   localparam logic [STDC_ADDR_W-1:0] STDC_OFS_CALIB = 4'hc;

   // Control and status fields
   localparam int STDC_CTRL_EN_BIT = 0;
   localparam int STDC_CTRL_INT_BIT = 1;
   localparam int STDC_CTRL_SRC_BIT = 2;
   localparam int STDC_CTRL_FLAG_BIT = 16;

   // Calibration fields
   localparam int STDC_CAL_REF_ABSENT_BIT = 31;
   localparam int STDC_CAL_INEXACT_BIT = 30;
   localparam logic STDC_CAL_REF_ABSENT_VAL = 1'h0;
   localparam logic STDC_CAL_INEXACT_VAL = 1'h1;

   // Zero values after reset, and the count of one
   localparam logic [STDC_CNT_W-1:0] STDC_CNT_RST = 24'h00_0000;
   localparam logic [STDC_CNT_W-1:0] STDC_CNT_ONE = 24'h00_0001;
   localparam logic [STDC_DATA_W-1:0] STDC_WORD_ZERO = 32'h0000_0000;

   // Divided tick: one pulse per eight processor clocks
   localparam int STDC_DIV_RATIO = 8;
   localparam logic [2:0] STDC_DIV_LAST = 3'(STDC_DIV_RATIO - 1);
   localparam logic [2:0] STDC_DIV_RST = 3'h0;

   // Counting clock choice
   typedef enum logic {
      STDC_SRC_DIV8 = 1'b0,
      STDC_SRC_CORE = 1'b1
   } stdc_src_type;
endpackage
`default_nettype wire

// ===== inc/stdc_tick_if.sv
`default_nettype none
interface stdc_tick_if;
   // One-cycle pulse per eight processor clocks
   logic div_tick;

   modport src (
      output div_tick
   );

   modport dst (
      input div_tick
   );
endinterface
`default_nettype wire

// ===== src/stdc_prescale.sv
`default_nettype none
module stdc_prescale
   import stdc_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Divided tick
   stdc_tick_if.src tick_bus
);
   logic [2:0] phase_q;
   logic tick_q;

   // Free running phase counter
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         phase_q <= STDC_DIV_RST;
      end else begin
         phase_q <= phase_q + 3'h1;
      end
   end

   // Single-cycle enable, no second clock domain
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= (phase_q == STDC_DIV_LAST); // RULE19
      end
   end

   assign tick_bus.div_tick = tick_q;

   sequence s_quiet_seven;
      !tick_q [*7];
   endsequence

   a_tick_spacing: assert property (@(posedge clk_i) disable iff (rst_i) // RULE19
      tick_q |=> s_quiet_seven ##1 tick_q)
      else $error("divided tick not every eight clocks");
endmodule
`default_nettype wire

// ===== src/stdc_timer.sv
// Functional notes
// RULE1: 24-bit down-counter reloads after reaching zero
// RULE2: Counting frozen while processor debug-halted
// RULE3: Wrap flag bit 16, cleared on read
// RULE4: Bit 2 picks divided or processor clock
// RULE5: Bit 1 enables request on zero
// RULE6: Enable bit loads restart, then counts
// RULE7: Restart value in bits 23:0 only
// RULE8: Events only on one-to-zero transition
// RULE9: Software programs N-1 for period N
// RULE10: Count register reads live counter value
// RULE11: Any count write clears counter and flag
// RULE12: Calibration bit 31 reads zero
// RULE13: Calibration bit 30 reads one
// RULE14: Calibration bits 23:0 hold fixed count
// RULE15: Counter stops when processor clock stops
// RULE16: Software uses aligned word accesses only
// RULE17: Restart and count contents undefined after reset
// RULE18: Software: restart, clear count, then control
// RULE19: Divided source steps once per eight clocks
`default_nettype none
module stdc_timer
   import stdc_pkg::*;
#(
   // Product-dependent calibration count, value arbitrary
   parameter logic [STDC_CNT_W-1:0] TEN_MILLISECOND_COUNT = 24'h00_0000
) (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   // Register port
   input wire logic [STDC_ADDR_W-1:0] ADDR_I,
   input wire logic [STDC_DATA_W-1:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [STDC_DATA_W-1:0] RDATA_O,
   // Processor status
   input wire logic DEBUG_HALT_I,
   // Exception request
   output logic TICK_REQ_O
);
   stdc_tick_if tick_bus ();

   logic en_q;
   logic int_en_q;
   stdc_src_type src_q;
   logic flag_q;
   logic [STDC_CNT_W-1:0] restart_q;
   logic [STDC_CNT_W-1:0] cnt_q;
   logic req_q;
   logic [STDC_DATA_W-1:0] rdata_q;
   logic [STDC_DATA_W-1:0] rdata_d;

   logic wr_ctrl;
   logic wr_restart;
   logic wr_cnt;
   logic rd_ctrl;
   logic tick_sel;
   logic step;
   logic en_rise;
   logic zero_evt;

   // Divide-by-eight tick source
   stdc_prescale u_prescale (
      .clk_i(CLK_I),
      .rst_i(SYS_RST_I),
      .tick_bus(tick_bus.src)
   );

   // Address decode, full word per register
   assign wr_ctrl = WR_I && (ADDR_I == STDC_OFS_CTRL);
   assign wr_restart = WR_I && (ADDR_I == STDC_OFS_RESTART);
   assign wr_cnt = WR_I && (ADDR_I == STDC_OFS_COUNT);
   assign rd_ctrl = RD_I && (ADDR_I == STDC_OFS_CTRL);

   // Counting clock select
   assign tick_sel = (src_q == STDC_SRC_CORE) ? 1'b1 : tick_bus.div_tick; // RULE4

   // One step per selected tick while enabled and not halted
   assign step = en_q && !DEBUG_HALT_I && tick_sel; // RULE2

   // Enable going from 0 to 1
   assign en_rise = wr_ctrl && WDATA_I[STDC_CTRL_EN_BIT] && !en_q; // RULE6

   // Only a one-to-zero step is an event
   assign zero_evt = step && !wr_cnt && !en_rise && (cnt_q == STDC_CNT_ONE); // RULE8

   // Control fields
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         en_q <= 1'b0;
         int_en_q <= 1'b0;
         src_q <= STDC_SRC_DIV8;
      end else if (wr_ctrl) begin
         en_q <= WDATA_I[STDC_CTRL_EN_BIT]; // RULE6
         int_en_q <= WDATA_I[STDC_CTRL_INT_BIT]; // RULE5
         src_q <= stdc_src_type'(WDATA_I[STDC_CTRL_SRC_BIT]); // RULE4
      end
   end

   // Restart value, upper bits dropped
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         restart_q <= STDC_CNT_RST; // RULE17
      end else if (wr_restart) begin
         restart_q <= WDATA_I[STDC_CNT_W-1:0]; // RULE7
      end
   end

   // Down-counter, advances only on edges of the running clock
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin // RULE15
      if (SYS_RST_I) begin
         cnt_q <= STDC_CNT_RST; // RULE17
      end else if (wr_cnt) begin
         cnt_q <= STDC_CNT_RST; // RULE11
      end else if (en_rise) begin
         cnt_q <= restart_q; // RULE6
      end else if (step) begin
         if (cnt_q == STDC_CNT_RST) begin
            cnt_q <= restart_q; // RULE1
         end else begin
            cnt_q <= cnt_q - STDC_CNT_ONE; // RULE1
         end
      end
   end

   // Sticky wrap flag, a new event wins over a read clear
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         flag_q <= 1'b0;
      end else if (zero_evt) begin
         flag_q <= 1'b1; // RULE3
      end else if (rd_ctrl || wr_cnt) begin
         flag_q <= 1'b0; // RULE3 RULE11
      end
   end

   // Exception request pulse
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         req_q <= 1'b0;
      end else begin
         req_q <= zero_evt && int_en_q; // RULE5
      end
   end

   assign TICK_REQ_O = req_q;

   // Read mux, unmapped and reserved bits read zero
   always_comb begin
      rdata_d = STDC_WORD_ZERO;
      if (RD_I) begin
         unique case (ADDR_I)
            STDC_OFS_CTRL: begin
               rdata_d[STDC_CTRL_EN_BIT] = en_q;
               rdata_d[STDC_CTRL_INT_BIT] = int_en_q;
               rdata_d[STDC_CTRL_SRC_BIT] = src_q;
               rdata_d[STDC_CTRL_FLAG_BIT] = flag_q; // RULE3
            end
            STDC_OFS_RESTART: begin
               rdata_d[STDC_CNT_W-1:0] = restart_q; // RULE7
            end
            STDC_OFS_COUNT: begin
               rdata_d[STDC_CNT_W-1:0] = cnt_q; // RULE10
            end
            STDC_OFS_CALIB: begin
               rdata_d[STDC_CAL_REF_ABSENT_BIT] = STDC_CAL_REF_ABSENT_VAL; // RULE12
               rdata_d[STDC_CAL_INEXACT_BIT] = STDC_CAL_INEXACT_VAL; // RULE13
               rdata_d[STDC_CNT_W-1:0] = TEN_MILLISECOND_COUNT; // RULE14
            end
            default: begin
               rdata_d = STDC_WORD_ZERO;
            end
         endcase
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         rdata_q <= STDC_WORD_ZERO;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign RDATA_O = rdata_q;

   // Checks
   logic quiet_bus;
   assign quiet_bus = !WR_I;

   sequence s_plain_step;
      step && quiet_bus && (cnt_q != STDC_CNT_RST);
   endsequence

   sequence s_wrap_step;
      step && quiet_bus && (cnt_q == STDC_CNT_RST);
   endsequence

   sequence s_enable_write;
      en_rise && !wr_restart;
   endsequence

   a_count_decrement: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE1
      s_plain_step |=> (cnt_q == $past(cnt_q) - STDC_CNT_ONE))
      else $error("counter did not decrement by one");

   a_count_reload: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE1
      s_wrap_step |=> (cnt_q == $past(restart_q)))
      else $error("counter did not reload after zero");

   a_halt_freeze: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE2
      (DEBUG_HALT_I && quiet_bus) |=> $stable(cnt_q))
      else $error("counter moved during debug halt");

   a_core_source: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE4
      (src_q == STDC_SRC_CORE && en_q && !DEBUG_HALT_I && quiet_bus
       && cnt_q > STDC_CNT_ONE) |=> (cnt_q != $past(cnt_q)))
      else $error("processor clock source did not step every cycle");

   a_div_source: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE4
      (src_q == STDC_SRC_DIV8 && !tick_bus.div_tick && quiet_bus) |=> $stable(cnt_q))
      else $error("divided source stepped without its tick");

   a_flag_readback: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE3
      rd_ctrl |=> (RDATA_O[STDC_CTRL_FLAG_BIT] == $past(flag_q)))
      else $error("wrap flag not returned on read");

   a_flag_read_clear: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE3
      (rd_ctrl && !zero_evt) |=> !flag_q)
      else $error("wrap flag not cleared by read");

   a_flag_set_wins: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE3
      zero_evt |=> flag_q)
      else $error("zero event lost");

   a_req_follows: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE5
      zero_evt |=> (TICK_REQ_O == $past(int_en_q)))
      else $error("request does not follow its enable");

   a_req_cause: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE5
      !(zero_evt && int_en_q) |=> !TICK_REQ_O)
      else $error("request without an enabled zero event");

   a_enable_load: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE6
      s_enable_write |=> (cnt_q == $past(restart_q)) && en_q)
      else $error("enable did not load restart value");

   a_disabled_hold: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE6
      (!en_q && quiet_bus) |=> $stable(cnt_q))
      else $error("counter moved while disabled");

   a_restart_field: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE7
      (RD_I && ADDR_I == STDC_OFS_RESTART) |=>
      (RDATA_O[31:24] == 8'h00) && (RDATA_O[23:0] == $past(restart_q)))
      else $error("restart field readback wrong");

   a_event_origin: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE8
      zero_evt |=> (cnt_q == STDC_CNT_RST))
      else $error("event not on one-to-zero step");

   a_zero_restart_quiet: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE8
      (restart_q == STDC_CNT_RST && cnt_q == STDC_CNT_RST) |-> !zero_evt)
      else $error("event from zero restart value");

   a_count_readback: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE10
      (RD_I && ADDR_I == STDC_OFS_COUNT) |=>
      (RDATA_O == {8'h00, $past(cnt_q)}))
      else $error("count readback wrong");

   a_count_write_clear: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE11
      wr_cnt |=> (cnt_q == STDC_CNT_RST) && !flag_q)
      else $error("count write did not clear");

   a_calib_value: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE12
      (RD_I && ADDR_I == STDC_OFS_CALIB) |=>
      (RDATA_O == {1'b0, 1'b1, 6'h00, TEN_MILLISECOND_COUNT}))
      else $error("calibration word wrong");

   a_read_only_once: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      !RD_I |=> (RDATA_O == STDC_WORD_ZERO))
      else $error("read data outside its cycle");

   a_ctrl_write: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE6
      wr_ctrl |=> (en_q == $past(WDATA_I[STDC_CTRL_EN_BIT]))
      && (int_en_q == $past(WDATA_I[STDC_CTRL_INT_BIT]))
      && (src_q == $past(WDATA_I[STDC_CTRL_SRC_BIT])))
      else $error("control write not taken");

   a_ctrl_readback: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE4
      rd_ctrl |=> (RDATA_O[STDC_CTRL_EN_BIT] == $past(en_q))
      && (RDATA_O[STDC_CTRL_INT_BIT] == $past(int_en_q))
      && (RDATA_O[STDC_CTRL_SRC_BIT] == $past(src_q)))
      else $error("control readback wrong");

   a_ctrl_reserved: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE3
      rd_ctrl |=> (RDATA_O[31:17] == 15'h0000) && (RDATA_O[15:3] == 13'h0000))
      else $error("control reserved bits not zero");

   a_restart_write: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE7
      wr_restart |=> (restart_q == $past(WDATA_I[STDC_CNT_W-1:0])))
      else $error("restart write not taken");

   a_div_step: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE19
      (src_q == STDC_SRC_DIV8 && en_q && !DEBUG_HALT_I && tick_bus.div_tick && quiet_bus
       && cnt_q > STDC_CNT_ONE) |=> (cnt_q == $past(cnt_q) - STDC_CNT_ONE))
      else $error("divided source missed its tick");

   a_enable_no_reload: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE6
      (wr_ctrl && en_q && !step) |=> $stable(cnt_q))
      else $error("enable rewrite reloaded counter");

   a_req_single: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE5
      TICK_REQ_O |=> !TICK_REQ_O)
      else $error("request longer than one cycle");

   a_req_enable_off: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE5
      !int_en_q |=> !TICK_REQ_O)
      else $error("request while request enable off");

   a_req_has_flag: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE3
      TICK_REQ_O |-> flag_q)
      else $error("request without wrap flag");

   a_disabled_quiet: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE6
      !en_q |=> !TICK_REQ_O)
      else $error("request while counter disabled");

   a_halt_no_req: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE2
      DEBUG_HALT_I |=> !TICK_REQ_O)
      else $error("request during debug halt");

   a_halt_flag: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE2
      (DEBUG_HALT_I && !flag_q) |=> !flag_q)
      else $error("wrap flag set during debug halt");

   a_flag_needs_event: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE8
      (!zero_evt && !flag_q) |=> !flag_q)
      else $error("wrap flag set without event");

   a_zero_restart_hold: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // RULE8
      (restart_q == STDC_CNT_RST && cnt_q == STDC_CNT_RST && !wr_restart) |=>
      (cnt_q == STDC_CNT_RST))
      else $error("zero restart value left zero");
endmodule
`default_nettype wire

// ===== testbench/system_tick_down_counter_tb.sv
`default_nettype none
module system_tick_down_counter_tb import stdc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   // Calibration count, value arbitrary
   localparam logic [STDC_CNT_W-1:0] CAL_COUNT = 24'h00_0a5c;
   localparam logic [STDC_DATA_W-1:0] CAL_WORD =
      {STDC_CAL_REF_ABSENT_VAL, STDC_CAL_INEXACT_VAL, 6'h00, CAL_COUNT};

   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wr_strobe = 1'b0;
   logic rd_strobe = 1'b0;
   logic halt = 1'b0;
   logic [STDC_ADDR_W-1:0] addr = 4'h0;
   logic [STDC_DATA_W-1:0] wdata = 32'h0000_0000;
   logic [STDC_DATA_W-1:0] rdata;
   logic req;
   int error_cnt = 0;
   int compares = 0;
   int cyc = 0;
   int req_cnt = 0;
   int base = 0;

   stdc_timer #(.TEN_MILLISECOND_COUNT(CAL_COUNT)) dut (
      .CLK_I(clk),
      .SYS_RST_I(rst),
      .ADDR_I(addr),
      .WDATA_I(wdata),
      .WR_I(wr_strobe),
      .RD_I(rd_strobe),
      .RDATA_O(rdata),
      .DEBUG_HALT_I(halt),
      .TICK_REQ_O(req)
   );

   always #5 clk = ~clk;

   // Counts request pulses
   always @(posedge clk) begin
      if (req === 1'b1) begin
         req_cnt <= req_cnt + 1;
      end
   end

   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         $display("ERROR %0t: timeout", $time);
         print_verdict();
      end
   end

   task automatic print_verdict();
      if (error_cnt == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic bus_wr(input logic [STDC_ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clk);
      wr_strobe <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_strobe <= 1'b0;
   endtask

   task automatic bus_rd(input logic [STDC_ADDR_W-1:0] a, output logic [31:0] d);
      @(posedge clk);
      rd_strobe <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_strobe <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic rd_chk(input logic [STDC_ADDR_W-1:0] a, input logic [31:0] exp);
      logic [31:0] d;
      bus_rd(a, d);
      chk(d, exp, "register read");
   endtask

   // Two count reads 16 edges apart, optional halt over 8 of them
   task automatic step_gap(input logic h, input logic [31:0] exp);
      logic [31:0] a;
      logic [31:0] b;
      bus_rd(STDC_OFS_COUNT, a);
      @(posedge clk);
      halt <= h;
      repeat (8) @(posedge clk);
      halt <= 1'b0;
      repeat (5) @(posedge clk);
      bus_rd(STDC_OFS_COUNT, b);
      chk(a - b, exp, "count progress");
   endtask

   // Enable for 22 cycles, then stop
   task automatic run(input logic [31:0] on, input logic [31:0] off);
      bus_wr(STDC_OFS_CTRL, on);
      repeat (20) @(posedge clk);
      bus_wr(STDC_OFS_CTRL, off);
      repeat (2) @(posedge clk);
   endtask

   initial begin
      repeat (20) @(posedge clk);
      #1;
      chk(rdata, 32'h0000_0000, "rdata in reset");
      chk({31'h0, req}, 32'h0000_0000, "request in reset");
      @(posedge clk);
      rst <= 1'b0;
      rd_chk(STDC_OFS_CTRL, 32'h0000_0000);
      rd_chk(STDC_OFS_CALIB, CAL_WORD);
      bus_wr(STDC_OFS_CALIB, 32'hffff_ffff);
      rd_chk(STDC_OFS_CALIB, {1'b0, 1'b1, 6'h00, CAL_COUNT});
      bus_wr(STDC_OFS_COUNT, 32'h0000_0007);
      rd_chk(STDC_OFS_COUNT, 32'h0000_0000);
      rd_chk(STDC_OFS_CTRL, 32'h0000_0000);
      bus_wr(STDC_OFS_RESTART, 32'hff00_0005);
      rd_chk(STDC_OFS_RESTART, 32'h0000_0005);
      bus_wr(STDC_OFS_RESTART, 32'h00ff_ffff);
      rd_chk(STDC_OFS_RESTART, 32'h00ff_ffff);
      // Period three, request on first zero
      bus_wr(STDC_OFS_RESTART, 32'h0000_0002);
      bus_wr(STDC_OFS_COUNT, 32'hdead_beef);
      bus_wr(STDC_OFS_CTRL, 32'h0000_0007);
      repeat (2) @(posedge clk);
      #1;
      chk({31'h0, req}, 32'h0000_0001, "request at zero");
      @(posedge clk);
      #1;
      chk({31'h0, req}, 32'h0000_0000, "request one cycle");
      repeat (2) @(posedge clk);
      #1;
      chk({31'h0, req}, 32'h0000_0001, "request period");
      bus_wr(STDC_OFS_CTRL, 32'h0000_0006);
      rd_chk(STDC_OFS_CTRL, 32'h0001_0006);
      rd_chk(STDC_OFS_CTRL, 32'h0000_0006);
      // Request disabled, flag still set
      base = req_cnt;
      run(32'h0000_0005, 32'h0000_0004);
      chk(32'(req_cnt - base), 32'h0000_0000, "no request");
      rd_chk(STDC_OFS_CTRL, 32'h0001_0004);
      run(32'h0000_0005, 32'h0000_0004);
      bus_wr(STDC_OFS_COUNT, 32'h0000_1234);
      rd_chk(STDC_OFS_CTRL, 32'h0000_0004);
      rd_chk(STDC_OFS_COUNT, 32'h0000_0000);
      // Zero restart gives no events
      bus_wr(STDC_OFS_RESTART, 32'h0000_0000);
      bus_wr(STDC_OFS_COUNT, 32'h0000_0000);
      base = req_cnt;
      run(32'h0000_0007, 32'h0000_0006);
      chk(32'(req_cnt - base), 32'h0000_0000, "zero restart request");
      rd_chk(STDC_OFS_CTRL, 32'h0000_0006);
      // Stepping rates and halt
      bus_wr(STDC_OFS_RESTART, 32'h0000_1000);
      bus_wr(STDC_OFS_COUNT, 32'h0000_0000);
      bus_wr(STDC_OFS_CTRL, 32'h0000_0005);
      step_gap(1'b0, 32'h0000_0010);
      step_gap(1'b1, 32'h0000_0008);
      bus_wr(STDC_OFS_CTRL, 32'h0000_0004);
      bus_wr(STDC_OFS_CTRL, 32'h0000_0001);
      step_gap(1'b0, 32'h0000_0002);
      step_gap(1'b1, 32'h0000_0001);
      print_verdict();
   end
endmodule
`default_nettype wire
